// ### core/xbar_consts.svh
/*
 * constants for the trigger bus crossbar: pattern geometry, field layout,
 * register offsets of the switch and the host's own command registers.
 * assumes inclusion by bare name from both ends, the checker and the bench.
 */
`ifndef XBAR_CONSTS_SVH
`define XBAR_CONSTS_SVH

`define XB_PINS 7
`define XB_PAT_BITS 56
`define XB_HALF_BITS 28
`define XB_FIELD_BITS 4
`define XB_FLD_OE 0
`define XB_FLD_SEL_LO 1
`define XB_FLD_SEL_HI 3
`define XB_PAT_RESET 56'h00000000000000
// idle levels of {connector trigger, counter 5, counter 2}: the trigger rests high
`define XB_SIG_IDLE 3'h4

// switch registers seen from the host
`define XB_REG_SHIFT_IN 4'h0
`define XB_REG_COMMIT 4'h1

// host command registers
`define HC_REG_PAT_LO 4'h0
`define HC_REG_PAT_HI 4'h1
`define HC_REG_STEER 4'h2
`define HC_REG_GO 4'h3
`define HC_REG_STATUS 4'h4
`define HC_STEER_P2_DRV 0
`define HC_STEER_P2_RCV 1
`define HC_STEER_P4_DRV 2
`define HC_STEER_P4_RCV 3

`endif

// ### core/xbar_pkg.sv
/*
 * types shared by the crossbar switch and its host loader.
 * assumes xbar_consts.svh sits on the include path.
 */
package xbar_pkg;
	typedef logic [6:0] pins_t;
	typedef logic [55:0] pattern_t;
	typedef logic [3:0] field_t;
	typedef logic [3:0] addr_t;
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_SHIFT = 2'b01,
		LD_COMMIT = 2'b10
	} load_state_e;
endpackage

// ### core/xbar_if.sv
/*
 * host-to-switch register path: 8-bit write port plus steering bits.
 * assumes one clock shared by both ends; the bench joins the modports.
 */
interface xbar_if (
	input wire logic clk
);
	import xbar_pkg::*;
	addr_t addr;
	logic [7:0] wdata;
	logic wr;
	logic pin2_drive_steer;
	logic pin2_receive_steer;
	logic pin4_drive_steer;
	logic pin4_receive_steer;

	modport dev (
		input addr,
		input wdata,
		input wr,
		input pin2_drive_steer,
		input pin2_receive_steer,
		input pin4_drive_steer,
		input pin4_receive_steer
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output pin2_drive_steer,
		output pin2_receive_steer,
		output pin4_drive_steer,
		output pin4_receive_steer
	);
endinterface

// ### core/xbar_switch.sv
/*
 * seven by seven trigger bus crossbar with board pin 2 / pin 4 steering.
 * routing comes from a 56-bit pattern shifted in a bit per write and made
 * live by a commit write; the steering bits act at once, with no commit.
 * assumes host writes over xbar_if on the same clock; pins are resolved
 * by the bench from the output enables (three-signal pins).
 * pin and counter inputs are asynchronous and pass a three-stage filter.
 */
// The address-and-strobe port and the address map are this design's own decisions.
`include "xbar_consts.svh"

module xbar_switch
	import xbar_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register path
	xbar_if.dev bus,
	// board-side pin wires
	input wire pins_t board_in,
	output logic [6:0] board_out,
	output logic [6:0] board_oe,
	// bus-side trigger lines
	input wire pins_t trig_in,
	output logic [6:0] trig_out,
	output logic [6:0] trig_oe,
	// board signals sharing pins 2 and 4
	input wire logic counter2_output,
	input wire logic counter5_output,
	input wire logic ext_timer_trigger_n,
	output logic counter1_gate,
	output logic timer_trigger_n
);
	// routing pattern, pin filters and the board's own pin levels
	pattern_t shift_q;
	pattern_t route_q;
	logic [2:0] board_s1_q, board_s2_q, board_s3_q;
	logic [2:0] drv_q;
	pins_t board_sync_q, board_s2p_q, board_s3p_q;
	pins_t trig_sync_q, trig_s2_q, trig_s3_q;
	pins_t board_v_q, trig_v_q;
	pins_t board_own;

	function automatic field_t field_of(input pattern_t p, input int half, input int pin);
		field_of = p[half * `XB_HALF_BITS + pin * `XB_FIELD_BITS +: `XB_FIELD_BITS];
	endfunction

	// drive steering takes board pin 2 or 4 away from the crossbar for a counter
	function automatic logic steer_takes(input int pin, input logic p2, input logic p4);
		steer_takes = (pin == 2 && p2) || (pin == 4 && p4);
	endfunction

	// shift chain and commit; the first bit written reaches pattern bit 0
	// after 56 writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			shift_q <= `XB_PAT_RESET;
		end else if (bus.wr && bus.addr == `XB_REG_SHIFT_IN) begin
			shift_q <= {bus.wdata[0], shift_q[55:1]};
		end
	end

	// live routing changes only on a commit, never while bits shift in
	always_ff @(posedge clk) begin
		if (!resetn) begin
			route_q <= `XB_PAT_RESET;
		end else if (bus.wr && bus.addr == `XB_REG_COMMIT) begin
			route_q <= shift_q;
		end
	end

	// board pins: three stages, a change counts when stages two and three agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			board_sync_q <= '0;
			board_s2p_q <= '0;
			board_s3p_q <= '0;
			board_v_q <= '0;
		end else begin
			board_sync_q <= board_in;
			board_s2p_q <= board_sync_q;
			board_s3p_q <= board_s2p_q;
			for (int i = 0; i < `XB_PINS; i++) begin
				if (board_s2p_q[i] == board_s3p_q[i]) board_v_q[i] <= board_s3p_q[i];
			end
		end
	end

	// trigger lines: the same filter as the board pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_sync_q <= '0;
			trig_s2_q <= '0;
			trig_s3_q <= '0;
			trig_v_q <= '0;
		end else begin
			trig_sync_q <= trig_in;
			trig_s2_q <= trig_sync_q;
			trig_s3_q <= trig_s2_q;
			for (int i = 0; i < `XB_PINS; i++) begin
				if (trig_s2_q[i] == trig_s3_q[i]) trig_v_q[i] <= trig_s3_q[i];
			end
		end
	end

	// counter outputs and connector trigger; stages start at the idle levels so
	// the release of reset cannot fake a falling edge on the active-low trigger
	always_ff @(posedge clk) begin
		if (!resetn) begin
			board_s1_q <= `XB_SIG_IDLE;
			board_s2_q <= `XB_SIG_IDLE;
			board_s3_q <= `XB_SIG_IDLE;
		end else begin
			board_s1_q <= {ext_timer_trigger_n, counter5_output, counter2_output};
			board_s2_q <= board_s1_q;
			board_s3_q <= board_s2_q;
		end
	end

	// filtered counter and connector levels
	always_ff @(posedge clk) begin
		if (!resetn) begin
			drv_q <= `XB_SIG_IDLE;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (board_s2_q[k] == board_s3_q[k]) drv_q[k] <= board_s3_q[k];
			end
		end
	end

	// board's own drive on pins 2 and 4; other pins' board signals live elsewhere
	always_comb begin
		board_own = board_v_q;
		if (bus.pin2_drive_steer) board_own[2] = drv_q[0];
		if (bus.pin4_drive_steer) board_own[4] = drv_q[1];
	end

	genvar g;
	generate
		for (g = 0; g < `XB_PINS; g++) begin : g_pin
			// this pin's fields: low half drives the bus line, high half the board pin
			field_t trig_fld;
			field_t board_fld;
			logic [2:0] trig_src;
			logic [2:0] board_src;
			logic board_take;

			assign trig_fld = field_of(route_q, 0, g);
			assign board_fld = field_of(route_q, 1, g);
			assign trig_src = trig_fld[`XB_FLD_SEL_HI:`XB_FLD_SEL_LO];
			assign board_src = board_fld[`XB_FLD_SEL_HI:`XB_FLD_SEL_LO];
			assign board_take = steer_takes(g, bus.pin2_drive_steer, bus.pin4_drive_steer);

			always_ff @(posedge clk) begin
				if (!resetn) begin
					trig_out[g] <= 1'b0;
					trig_oe[g] <= 1'b0;
					board_out[g] <= 1'b0;
					board_oe[g] <= 1'b0;
				end else begin
					trig_oe[g] <= trig_fld[`XB_FLD_OE];
					trig_out[g] <= board_own[trig_src % 3'h7];
					board_oe[g] <= board_fld[`XB_FLD_OE] || board_take;
					if (board_take) begin
						board_out[g] <= (g == 2) ? drv_q[0] : drv_q[1];
					end else begin
						board_out[g] <= trig_v_q[board_src % 3'h7];
					end
				end
			end
		end
	endgenerate

	// gate and trigger inputs taken from the pins when receive steering is set
	always_ff @(posedge clk) begin
		if (!resetn) begin
			counter1_gate <= 1'b0;
			timer_trigger_n <= 1'b1;
		end else begin
			// both pin 2 steers loop counter 2 straight into the gate; software avoids it
			counter1_gate <= bus.pin2_receive_steer ? board_own[2] : 1'b0;
			if (bus.pin4_receive_steer) begin
				timer_trigger_n <= board_own[4];
			end else begin
				// receive clear: the connector pin, not the crossbar, sets the trigger
				timer_trigger_n <= drv_q[2];
			end
		end
	end
endmodule

// ### core/xbar_loader.sv
/*
 * host end: takes a 56-bit pattern and steering bits from software and
 * shifts the pattern into the switch one bit per write, then commits.
 * assumes the switch shares clk and latches each write on the same edge.
 */
`include "xbar_consts.svh"

module xbar_loader
	import xbar_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// software port
	input wire addr_t addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// switch side
	xbar_if.host bus
);
	load_state_e state_q;
	pattern_t pat_q;
	logic [5:0] idx_q;
	logic [3:0] steer_q;
	logic done_q;
	logic busy;

	assign busy = state_q != LD_IDLE;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pat_q <= `XB_PAT_RESET;
		end else if (wr && !busy && addr == `HC_REG_PAT_LO) begin
			pat_q[31:0] <= wdata;
		end else if (wr && !busy && addr == `HC_REG_PAT_HI) begin
			pat_q[55:32] <= wdata[23:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			steer_q <= 4'h0;
		end else if (wr && addr == `HC_REG_STEER) begin
			steer_q <= wdata[3:0];
		end
	end

	// sequencer: 56 shift writes in ascending bit order, then one commit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= LD_IDLE;
			idx_q <= 6'h00;
			done_q <= 1'b0;
		end else begin
			unique case (state_q)
				LD_IDLE: begin
					if (wr && addr == `HC_REG_GO) begin
						state_q <= LD_SHIFT;
						idx_q <= 6'h00;
						done_q <= 1'b0;
					end
				end
				LD_SHIFT: begin
					if (idx_q == 6'(`XB_PAT_BITS - 1)) state_q <= LD_COMMIT;
					idx_q <= idx_q + 6'h01;
				end
				LD_COMMIT: begin
					state_q <= LD_IDLE;
					done_q <= 1'b1;
				end
				default: state_q <= LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus.wr <= 1'b0;
			bus.addr <= 4'h0;
			bus.wdata <= 8'h00;
		end else begin
			bus.wr <= busy;
			bus.addr <= (state_q == LD_COMMIT) ? `XB_REG_COMMIT : `XB_REG_SHIFT_IN;
			bus.wdata <= (state_q == LD_SHIFT) ? {7'h00, pat_q[idx_q]} : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus.pin2_drive_steer <= 1'b0;
			bus.pin2_receive_steer <= 1'b0;
			bus.pin4_drive_steer <= 1'b0;
			bus.pin4_receive_steer <= 1'b0;
		end else begin
			bus.pin2_drive_steer <= steer_q[`HC_STEER_P2_DRV];
			bus.pin2_receive_steer <= steer_q[`HC_STEER_P2_RCV];
			bus.pin4_drive_steer <= steer_q[`HC_STEER_P4_DRV];
			bus.pin4_receive_steer <= steer_q[`HC_STEER_P4_RCV];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			unique case (addr)
				`HC_REG_PAT_LO: rdata <= pat_q[31:0];
				`HC_REG_PAT_HI: rdata <= {8'h00, pat_q[55:32]};
				`HC_REG_STEER: rdata <= {28'h0000000, steer_q};
				`HC_REG_STATUS: rdata <= {30'h00000000, done_q, busy};
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule

// ### dv/xbar_checker.sv
/*
 * assertions on the host-to-switch write path of the crossbar.
 * assumes the bench wires it beside the xbar_if instance, same clock.
 */
`include "xbar_consts.svh"

module xbar_checker
	import xbar_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// switch write port
	input wire addr_t addr,
	input wire logic [7:0] wdata,
	input wire logic wr
);
	logic [6:0] cnt_q;
	wire logic sh = wr && addr == `XB_REG_SHIFT_IN;
	wire logic cm = wr && addr == `XB_REG_COMMIT;

	// shifts seen since the last commit
	always_ff @(posedge clk) begin
		if (!resetn || cm)
			cnt_q <= '0;
		else if (sh)
			cnt_q <= cnt_q + 7'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_commit_zero_data: assert property (cm |-> wdata == 8'h00)
		else $error("commit carries nonzero data");
	a_commit_full_count: assert property (cm |-> cnt_q == 7'h38)
		else $error("commit after wrong shift count");
	a_shift_count_cap: assert property (cnt_q <= 7'h38)
		else $error("more shifts than pattern bits");
	a_write_addr_legal: assert property (wr |-> addr inside {`XB_REG_SHIFT_IN, `XB_REG_COMMIT})
		else $error("write to unknown switch address");
	a_burst_then_commit: assert property ($rose(wr) |-> sh ##55 sh ##1 cm)
		else $error("burst is not 56 shifts then commit");
	a_commit_ends_burst: assert property (cm |=> !wr)
		else $error("write right after commit");
	a_shift_run_on: assert property (sh |=> wr)
		else $error("gap inside shift burst");
	a_commit_after_shift: assert property (cm |-> $past(sh))
		else $error("commit not preceded by shift");
endmodule

// ### dv/tb_trigger_bus_crossbar_switch.sv
/*
 * bench joining loader and switch; drives software port and pin far ends.
 * assumes pins resolve as own drive where enabled, else far-end level.
 */
`include "xbar_consts.svh"

module tb_trigger_bus_crossbar_switch;
	import xbar_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, wr, rd, c2, c5, etmr, gate, tmr_n;
	addr_t addr;
	logic [31:0] wdata, rdata, v;
	pins_t ext_b, ext_t, b_in, t_in;
	logic [6:0] b_out, b_oe, t_out, t_oe;
	int err_total, comparisons, cyc;

	xbar_if u_xbar_if (.clk(clk));
	xbar_loader u_xbar_loader (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .bus(u_xbar_if.host));
	xbar_switch u_xbar_switch (.clk(clk), .resetn(resetn), .bus(u_xbar_if.dev),
		.board_in(b_in), .board_out(b_out), .board_oe(b_oe), .trig_in(t_in),
		.trig_out(t_out), .trig_oe(t_oe), .counter2_output(c2), .counter5_output(c5),
		.ext_timer_trigger_n(etmr), .counter1_gate(gate), .timer_trigger_n(tmr_n));
	xbar_checker u_xbar_checker (.clk(clk), .resetn(resetn), .addr(u_xbar_if.addr),
		.wdata(u_xbar_if.wdata), .wr(u_xbar_if.wr));

	// wire level: own drive where enabled, far end otherwise
	assign b_in = (b_oe & b_out) | (~b_oe & ext_b);
	assign t_in = (t_oe & t_out) | (~t_oe & ext_t);

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task sw_wr(input addr_t a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task sw_rd(input addr_t a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task ld(input pattern_t p);
		sw_wr(`HC_REG_PAT_LO, p[31:0]);
		sw_wr(`HC_REG_PAT_HI, {8'h00, p[55:32]});
		sw_wr(`HC_REG_GO, 32'h0);
	endtask

	// steer levels, far ends, then gate/trigger and pin 2/4 drive
	task st(input logic [3:0] s, input logic a2, a5, input pins_t b, input logic t, eg, et);
		sw_wr(`HC_REG_STEER, {28'h0, s});
		c2 <= a2;
		c5 <= a5;
		ext_b <= b;
		etmr <= t;
		repeat (8) @(negedge clk);
		chk({gate, tmr_n, b_oe[4], b_oe[2], b_out[4] & b_oe[4], b_out[2] & b_oe[2]},
			{eg, et, s[2], s[0], s[2] & a5, s[0] & a2});
	endtask

	initial begin
		{resetn, wr, rd, c2, c5, etmr} = 6'h01;
		addr = 4'h0;
		wdata = 32'h0;
		ext_b = 7'h00;
		ext_t = 7'h00;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		// several edges out of reset: no false trigger edge from the filter stages
		repeat (4) @(negedge clk);
		chk({b_oe, t_oe, gate, tmr_n}, {14'h0000, 2'h1});
		$display("reset test done");
		// board pin 0 from bus line 3, bus line 4 from board pin 5
		@(posedge clk);
		ext_t <= 7'h08;
		ext_b <= 7'h20;
		ld(56'h000000700B0000);
		repeat (30) @(negedge clk);
		chk({b_oe, t_oe}, 14'h0000);
		repeat (40) @(negedge clk);
		sw_rd(`HC_REG_STATUS, v);
		chk(v, 32'h2);
		chk({b_oe, b_out & b_oe, t_oe, t_out & t_oe}, {7'h01, 7'h01, 7'h10, 7'h10});
		sw_rd(`HC_REG_PAT_LO, v);
		chk(v, 32'h700B0000);
		@(posedge clk);
		ext_t <= 7'h77;
		ext_b <= 7'h5F;
		repeat (8) @(negedge clk);
		chk({b_out[0], t_out[4]}, 2'h0);
		sw_rd(4'hF, v);
		chk(v, 32'h0);
		$display("routing test done");
		st(4'h0, 1, 1, 7'h7F, 0, 0, 0);
		st(4'h0, 0, 0, 7'h7F, 1, 0, 1);
		st(4'h1, 1, 0, 7'h00, 1, 0, 1);
		st(4'h2, 1, 0, 7'h00, 1, 0, 1);
		st(4'h2, 0, 0, 7'h04, 1, 1, 1);
		st(4'h3, 1, 0, 7'h00, 1, 1, 1);
		st(4'h3, 0, 0, 7'h7F, 1, 0, 1);
		st(4'h4, 0, 1, 7'h00, 0, 0, 0);
		st(4'h8, 0, 0, 7'h00, 1, 0, 0);
		st(4'h8, 0, 0, 7'h10, 0, 0, 1);
		st(4'hC, 0, 0, 7'h7F, 1, 0, 0);
		st(4'hC, 0, 1, 7'h00, 0, 0, 1);
		$display("steering test done");
		st(4'h0, 0, 0, 7'h00, 1, 0, 1);
		ld(56'h0);
		repeat (70) @(negedge clk);
		chk({b_oe, t_oe}, 14'h0000);
		$display("clear test done");
		report_and_stop;
	end
endmodule
